/* File: cmpd_top.sv */
// comparator digital control with axi4-lite register slave
`timescale 1ns/1ns
`include "cmpd_consts.svh"

////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for levels from outside the aclk domain; only the
// second stage is read, so a metastable first stage never reaches logic
module cmpd_sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_r
);
  logic [W-1:0] stage_r;
  // both stages hold with clk_en low, like every other flop of the block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_r <= '0;
      q_r <= '0;
    end else if (clk_en) begin
      stage_r <= d;
      q_r <= stage_r;
    end
  end
endmodule : cmpd_sync2

////////////////////////////////////////////////////////////////////////
module cmpd_top
  import cmpd_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_raw_in,
  input wire logic tmr_src_clk,
  input wire logic tmr_prescale_out,
  input wire logic tmr_prescale_en,
  input wire logic tmr_clk_is_sysclk,
  input wire logic sleep_mode,
  input wire logic opamp_enable,
  input wire logic shutdown_source_enable,
  input wire logic [PORT_W-1:0] port_pins_in,
  output logic [3:0] pos_route_r,
  output logic [2:0] neg_route_r,
  output logic neg_from_opamp_r,
  output logic analog_power_r,
  output logic speed_power_sel_r,
  output logic hyst_enable_r,
  output logic cmp_out_r,
  output logic cwg_shutdown_r,
  output logic cmp_irq_r,
  output logic wake_r
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before anything reads a pin
  logic raw_sync;
  logic tclk_sync;
  logic pclk_sync;
  logic [PORT_W-1:0] port_sync;
  // comparator result arrives from the analog side with no relation to aclk
  cmpd_sync2 #(.W(1)) u_raw_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d(cmp_raw_in),
    .q_r(raw_sync)
  );
  // timer source clock is sampled as a level; edges are found after the sync
  cmpd_sync2 #(.W(1)) u_tclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d(tmr_src_clk),
    .q_r(tclk_sync)
  );
  // prescaler output, same treatment as the undivided clock
  cmpd_sync2 #(.W(1)) u_pclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d(tmr_prescale_out),
    .q_r(pclk_sync)
  );
  // port pins are read by software only, so bitwise sync is enough
  cmpd_sync2 #(.W(PORT_W)) u_port_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d(port_pins_in),
    .q_r(port_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  logic irq_en_r;
  logic irq_flag_r;
  logic [PORT_W-1:0] analog_select_reg_r;
  logic flag_clr;
  logic edge_hit;

  ////////////////////////////////////////////////////////////////////////
  // comparator output path
  logic cmp_pol;
  logic sync_clk_prev_r;
  logic sync_latch_r;
  logic cmp_view;
  logic cmp_view_prev_r;
  logic sync_clk;
  logic sync_fall;

  // disabled comparator reads low, so toggling on or polarity still moves the view
  assign cmp_pol = (ctrl_r[`CMPD_CTRL_ON] & raw_sync) ^ ctrl_r[`CMPD_CTRL_POL];
  // prescaled clock replaces the raw timer clock when the prescaler is in use
  assign sync_clk = tmr_prescale_en ? pclk_sync : tclk_sync;
  // timer counts on rising; we latch on falling, so no race with the count
  assign sync_fall = sync_clk_prev_r & ~sync_clk;

  // falling-edge latch; a halted timer in sleep freezes the synced output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_clk_prev_r <= 1'b0;
      sync_latch_r <= 1'b0;
    end else if (clk_en) begin
      sync_clk_prev_r <= sync_clk;
      if (sync_fall && !(sleep_mode && tmr_clk_is_sysclk)) begin
        sync_latch_r <= cmp_pol;
      end
    end
  end

  assign cmp_view = ctrl_r[`CMPD_CTRL_SYNC] ? sync_latch_r : cmp_pol;

  // output latched every cycle (one cycle per instruction here)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_view_prev_r <= 1'b0;
      cmp_out_r <= 1'b0;
      cwg_shutdown_r <= 1'b0;
    end else if (clk_en) begin
      cmp_view_prev_r <= cmp_view;
      cmp_out_r <= cmp_view;
      cwg_shutdown_r <= cmp_view & shutdown_source_enable;
    end
  end

  logic rise_det;
  logic fall_det;
  assign rise_det = cmp_view & ~cmp_view_prev_r;
  assign fall_det = ~cmp_view & cmp_view_prev_r;
  assign edge_hit = (rise_det & cfg_r[`CMPD_CFG_INTP]) | (fall_det & cfg_r[`CMPD_CFG_INTN]);

  // interrupt flag: set wins over a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (edge_hit) begin
        irq_flag_r <= 1'b1;
      end else if (flag_clr) begin
        irq_flag_r <= 1'b0;
      end
    end
  end

  // request and wake outputs, only with the enable set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else if (clk_en) begin
      cmp_irq_r <= irq_flag_r & irq_en_r;
      wake_r <= irq_flag_r & irq_en_r & sleep_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input routing, all off when disabled
  logic [3:0] pos_route_nxt;
  logic [2:0] neg_route_nxt;
  always_comb begin
    pos_route_nxt = 4'h0;
    neg_route_nxt = 3'h0;
    if (ctrl_r[`CMPD_CTRL_ON]) begin
      unique case (cfg_r[5:3])
        `CMPD_PCH_PIN: pos_route_nxt = CMPD_VP_PIN;
        `CMPD_PCH_DAC: pos_route_nxt = CMPD_VP_DAC;
        `CMPD_PCH_FVR: pos_route_nxt = CMPD_VP_FVR;
        default: pos_route_nxt = CMPD_VP_GND;
      endcase
      unique case (cfg_r[2:0])
        `CMPD_NCH_PIN: neg_route_nxt = CMPD_VN_PIN;
        `CMPD_NCH_FVR: neg_route_nxt = CMPD_VN_FVR;
        default: neg_route_nxt = CMPD_VN_GND;
      endcase
    end
  end

  // routes and analog controls leave on flops so the analog side sees no glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_route_r <= 4'h0;
      neg_route_r <= 3'h0;
      neg_from_opamp_r <= 1'b0;
      analog_power_r <= 1'b0;
      speed_power_sel_r <= 1'b0;
      hyst_enable_r <= 1'b0;
    end else if (clk_en) begin
      pos_route_r <= pos_route_nxt;
      neg_route_r <= neg_route_nxt;
      // shared pin: amplifier output wins when both functions are on
      neg_from_opamp_r <= (neg_route_nxt == CMPD_VN_PIN) & opamp_enable;
      analog_power_r <= ctrl_r[`CMPD_CTRL_ON];
      speed_power_sel_r <= ctrl_r[`CMPD_CTRL_SP];
      hyst_enable_r <= ctrl_r[`CMPD_CTRL_HYS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data accepted in either order
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

  // readies pulse while idle, so a held address or data beat is never overwritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMPD_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready;
      s_axi_wready <= ~w_held_r & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_r)
          `CMPD_OFS_CTRL, `CMPD_OFS_CFG, `CMPD_OFS_IRQ, `CMPD_OFS_OUT, `CMPD_OFS_PORT, `CMPD_OFS_MISC:
            s_axi_bresp <= `CMPD_RESP_OKAY;
          default: s_axi_bresp <= `CMPD_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes, byte lane 0 carries the 8-bit registers
  logic wr_lane0;
  assign wr_lane0 = wr_go & w_strb_r[0];
  // writing zero to the flag bit clears it; hardware never clears it itself
  assign flag_clr = wr_lane0 & (aw_addr_r == `CMPD_OFS_IRQ) & ~w_data_r[`CMPD_IRQ_IF];
  // software view of control, config, enable and analog select bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CMPD_CTRL_RST;
      cfg_r <= `CMPD_CFG_RST;
      irq_en_r <= 1'b0;
      analog_select_reg_r <= '0;
    end else if (clk_en && wr_lane0) begin
      unique case (aw_addr_r)
        // output status bit and unused bits are read-only
        `CMPD_OFS_CTRL: ctrl_r <= w_data_r[7:0] & 8'h97;
        `CMPD_OFS_CFG: cfg_r <= w_data_r[7:0] & 8'hff;
        `CMPD_OFS_IRQ: irq_en_r <= w_data_r[`CMPD_IRQ_IE];
        `CMPD_OFS_PORT: analog_select_reg_r <= w_data_r[PORT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    unique case (s_axi_araddr)
      `CMPD_OFS_CTRL: rd_word[7:0] = {ctrl_r[7], cmp_out_r, ctrl_r[5:0]};
      `CMPD_OFS_CFG: rd_word[7:0] = cfg_r;
      `CMPD_OFS_IRQ: rd_word[1:0] = {irq_en_r, irq_flag_r};
      `CMPD_OFS_OUT: rd_word[0] = cmp_out_r;
      `CMPD_OFS_PORT: rd_word[PORT_W-1:0] = port_sync & ~analog_select_reg_r;
      `CMPD_OFS_MISC: rd_word[PORT_W-1:0] = analog_select_reg_r;
      default: rd_word = 32'h0;
    endcase
  end

  // read answer is registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CMPD_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        unique case (s_axi_araddr)
          `CMPD_OFS_CTRL, `CMPD_OFS_CFG, `CMPD_OFS_IRQ, `CMPD_OFS_OUT, `CMPD_OFS_PORT, `CMPD_OFS_MISC:
            s_axi_rresp <= `CMPD_RESP_OKAY;
          default: s_axi_rresp <= `CMPD_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : cmpd_top

/* File: cmpd_consts.svh */
// constants for the comparator digital control block
// Summary of operation
// - with sync_to_timer set the output passes a latch on the timer clock
// - the synchronising latch captures on the falling timer source clock edge
// - with a prescaler the latch edge comes from the prescaler output
// - timer counts on rising edge, opposite the latch edge, avoiding races
// - rising and falling detectors set the flag when their enable is set
// - only a software write clears the interrupt flag
// - an edge in the clearing cycle leaves the flag set
// - toggling polarity or enable while off still reaches the edge detectors
// - three-bit positive select routes pin, converter, reference or ground
// - three-bit negative select routes pin, reference or analog ground
// - with the comparator disabled all its inputs are disconnected
// - amplifier output overrides the shared inverting pin when both enabled
// - active output with shutdown enable stops the waveform generator at once
// - works in sleep; synced output stops when timer runs from system clock
// - an enabled comparator interrupt wakes the device from sleep
// - port reads return zero for pins configured as analog
// - polarity bit set inverts the output, clear leaves it as is
// - output latched once per instruction cycle, readable in two places
`ifndef CMPD_CONSTS_SVH
`define CMPD_CONSTS_SVH
`define CMPD_OFS_CTRL 8'h00
`define CMPD_OFS_CFG 8'h04
`define CMPD_OFS_IRQ 8'h08
`define CMPD_OFS_OUT 8'h0c
`define CMPD_OFS_PORT 8'h10
`define CMPD_OFS_MISC 8'h14
`define CMPD_CTRL_ON 7
`define CMPD_CTRL_OUT 6
`define CMPD_CTRL_POL 4
`define CMPD_CTRL_SP 2
`define CMPD_CTRL_HYS 1
`define CMPD_CTRL_SYNC 0
`define CMPD_CFG_INTP 7
`define CMPD_CFG_INTN 6
`define CMPD_IRQ_IF 0
`define CMPD_IRQ_IE 1
`define CMPD_CTRL_RST 8'h00
`define CMPD_CFG_RST 8'h00
`define CMPD_PCH_PIN 3'h0
`define CMPD_PCH_DAC 3'h1
`define CMPD_PCH_FVR 3'h2
`define CMPD_NCH_PIN 3'h0
`define CMPD_NCH_FVR 3'h1
`define CMPD_RESP_OKAY 2'h0
`define CMPD_RESP_SLVERR 2'h2
`endif

/* File: cmpd_pkg.sv */
// types for the comparator digital control block
package cmpd_pkg;
  typedef enum logic [3:0] {
    CMPD_VP_PIN = 4'b0001,
    CMPD_VP_DAC = 4'b0010,
    CMPD_VP_FVR = 4'b0100,
    CMPD_VP_GND = 4'b1000
  } cmpd_vp_t;
  typedef enum logic [2:0] {
    CMPD_VN_PIN = 3'b001,
    CMPD_VN_FVR = 3'b010,
    CMPD_VN_GND = 3'b100
  } cmpd_vn_t;
endpackage : cmpd_pkg

/* File: cmpd_far_model.sv */
// timer and waveform generator model standing at the far side
`timescale 1ns/1ns
module cmpd_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic cwg_stop,
  output logic tmr_src_clk,
  output logic tmr_prescale_out,
  output logic [7:0] tmr_count
);
  logic [1:0] div_r;
  ////////////////////////////////////////////////////////////////
  // timer clocks stand still low while not running, like a gated source
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_r <= 2'h0;
      tmr_src_clk <= 1'b0;
      tmr_prescale_out <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) tmr_src_clk <= ~tmr_src_clk;
      if (div_r == 2'h3 && !tmr_src_clk) tmr_prescale_out <= ~tmr_prescale_out;
    end
  end
  // count on the rising timer edge only; a shutdown halts the generator
  always_ff @(posedge aclk) begin
    if (!aresetn) tmr_count <= 8'h00;
    else if (run && div_r == 2'h3 && !tmr_src_clk && !cwg_stop) tmr_count <= tmr_count + 8'h01;
  end
endmodule : cmpd_far_model

/* File: cmpd_monitor.sv */
// concurrent checks on the ports of the comparator control block
`timescale 1ns/1ns
module cmpd_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic sleep_mode,
  input wire logic shutdown_source_enable,
  input wire logic [3:0] pos_route_r,
  input wire logic [2:0] neg_route_r,
  input wire logic neg_from_opamp_r,
  input wire logic analog_power_r,
  input wire logic cmp_out_r,
  input wire logic cwg_shutdown_r,
  input wire logic cmp_irq_r,
  input wire logic wake_r
);
  logic [3:0] wr_age_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // cycles since the last write beat, saturating so old writes never excuse a drop
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_age_r <= 4'hf;
    else if (s_axi_wvalid && s_axi_wready) wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hf) wr_age_r <= wr_age_r + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  a_shutdown_follows: assert property ($past(clk_en) |-> cwg_shutdown_r == (cmp_out_r & $past(shutdown_source_enable)))
    else $error("shutdown does not follow comparator");
  a_wake_needs_irq: assert property ($past(clk_en) |-> wake_r == (cmp_irq_r & $past(sleep_mode)))
    else $error("wake differs from irq and sleep");
  a_routes_off: assert property (!analog_power_r |-> pos_route_r == 4'h0 && neg_route_r == 3'h0)
    else $error("routes connected while disabled");
  a_routes_onehot: assert property (analog_power_r |-> $onehot(pos_route_r) && $onehot(neg_route_r))
    else $error("route select not one-hot");
  a_opamp_on_pin: assert property (neg_from_opamp_r |-> neg_route_r == 3'h1)
    else $error("opamp route without pin route");
  a_flag_no_hw_clear: assert property ($fell(cmp_irq_r) |-> wr_age_r < 4'h6)
    else $error("interrupt dropped without a write");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_read_answers: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule : cmpd_monitor
bind cmpd_top cmpd_monitor u_mon (.aclk, .aresetn, .clk_en, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .sleep_mode, .shutdown_source_enable, .pos_route_r, .neg_route_r, .neg_from_opamp_r, .analog_power_r,
  .cmp_out_r, .cwg_shutdown_r, .cmp_irq_r, .wake_r);

/* File: comparator_digital_control_test.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`include "cmpd_consts.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module comparator_digital_control_test;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, raw = 1'b0, pre_en = 1'b0, sysclk = 1'b0;
  logic sleep = 1'b0, opamp = 1'b0, sse = 1'b0, tmr_run = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pins = 8'h00, v, p;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf, pos;
  logic [1:0] bresp, rresp, rs, bs;
  logic [2:0] neg;
  logic awready, wready, bvalid, arready, rvalid, nopa, apow, spd, hys, cout, complementary_waveform_gen, irq, wake;
  wire tmr_clk, tmr_pre;
  wire [7:0] tmr_cnt;
  int bad_count = 0, samples_checked = 0, seed = 18699;
  cmpd_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_raw_in(raw),
    .tmr_src_clk(tmr_clk), .tmr_prescale_out(tmr_pre), .tmr_prescale_en(pre_en), .tmr_clk_is_sysclk(sysclk),
    .sleep_mode(sleep), .opamp_enable(opamp), .shutdown_source_enable(sse), .port_pins_in(pins),
    .pos_route_r(pos), .neg_route_r(neg), .neg_from_opamp_r(nopa), .analog_power_r(apow),
    .speed_power_sel_r(spd), .hyst_enable_r(hys), .cmp_out_r(cout), .cwg_shutdown_r(complementary_waveform_gen), .cmp_irq_r(irq),
    .wake_r(wake));
  cmpd_far_model u_far (.aclk(aclk), .aresetn(aresetn), .run(tmr_run), .cwg_stop(complementary_waveform_gen), .tmr_src_clk(tmr_clk),
    .tmr_prescale_out(tmr_pre), .tmr_count(tmr_cnt));
  ////////////////////////////////////////////////////////////////
  // 50 ns clock and a watchdog so a hang still reaches the verdict
  initial begin
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    $display("unexpected run length exp 0 got 1");
    close_out();
  end
  function automatic logic [3:0] exp_pos(input logic [2:0] s);
    return (s == `CMPD_PCH_PIN) ? 4'h1 : (s == `CMPD_PCH_DAC) ? 4'h2 : (s == `CMPD_PCH_FVR) ? 4'h4 : 4'h8;
  endfunction : exp_pos
  function automatic logic [2:0] exp_neg(input logic [2:0] s);
    return (s == `CMPD_NCH_PIN) ? 3'h1 : (s == `CMPD_NCH_FVR) ? 3'h2 : 3'h4;
  endfunction : exp_neg
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  ////////////////////////////////////////////////////////////////
  // bus cycles: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge aclk);
      if (!aw && awready) begin aw = 1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1; wvalid <= 1'b0; end
    end
    bs = bresp; bready <= 1'b0;
    if (n == 50) begin bad_count++; $display("unexpected write wait exp 1 got 0"); close_out(); end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n;
    bit ar;
    ar = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge aclk);
      if (!ar && arready) begin ar = 1; arvalid <= 1'b0; end
    end
    rd = rdata; rs = rresp; rready <= 1'b0;
    if (n == 50) begin bad_count++; $display("unexpected read wait exp 1 got 0"); close_out(); end
  endtask : axi_rd
  ////////////////////////////////////////////////////////////////
  // main sequence; routes, flags, outputs, port reads, then the timer latch
  initial begin
    tick(16);
    aresetn <= 1'b1;
    axi_rd(`CMPD_OFS_CTRL); `CHK("ctrl reset", 32'h0, rd)
    axi_rd(8'h18); `CHK("unmapped resp", `CMPD_RESP_SLVERR, rs) `CHK("unmapped data", 32'h0, rd)
    axi_wr(8'h18, 8'hff); `CHK("unmapped wr resp", `CMPD_RESP_SLVERR, bs)
    $display("test reset done");
    axi_wr(`CMPD_OFS_CTRL, 8'h80); `CHK("wr resp", `CMPD_RESP_OKAY, bs)
    for (int i = 0; i < 8; i++) begin
      v = i[7:0];
      axi_wr(`CMPD_OFS_CFG, {2'b00, v[2:0], v[2:0]}); tick(4);
      `CHK("pos route", exp_pos(v[2:0]), pos)
      `CHK("neg route", exp_neg(v[2:0]), neg)
    end
    opamp <= 1'b1; axi_wr(`CMPD_OFS_CFG, 8'h00); tick(4); `CHK("opamp route", 1'b1, nopa)
    axi_wr(`CMPD_OFS_CTRL, 8'h00); tick(4); `CHK("pos off", 4'h0, pos) `CHK("neg off", 3'h0, neg)
    opamp <= 1'b0; $display("test routes done");
    axi_wr(`CMPD_OFS_CFG, 8'hc0); axi_wr(`CMPD_OFS_IRQ, 8'h02); axi_wr(`CMPD_OFS_CTRL, 8'h10); tick(8);
    `CHK("pol while off", 1'b1, cout)
    `CHK("edge irq", 1'b1, irq)
    sleep <= 1'b1; tick(4); `CHK("wake", 1'b1, wake)
    sleep <= 1'b0; axi_rd(`CMPD_OFS_IRQ); `CHK("flag kept", 32'h3, rd)
    axi_wr(`CMPD_OFS_IRQ, 8'h03); tick(4); `CHK("write one keeps", 1'b1, irq)
    axi_wr(`CMPD_OFS_IRQ, 8'h02); tick(4); `CHK("flag cleared", 1'b0, irq)
    $display("test irq done");
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      raw <= v[0]; sse <= v[2]; axi_wr(`CMPD_OFS_CTRL, {3'b100, v[1], 1'b0, v[3], v[4], 1'b0}); tick(6);
      `CHK("power", 1'b1, apow) `CHK("speed", v[3], spd) `CHK("hyst", v[4], hys)
      `CHK("cmp out", v[0] ^ v[1], cout)
      `CHK("shutdown", (v[0] ^ v[1]) & v[2], complementary_waveform_gen)
      axi_rd(`CMPD_OFS_OUT); `CHK("out reg", v[0] ^ v[1], rd[0])
      axi_rd(`CMPD_OFS_CTRL); `CHK("status bit", v[0] ^ v[1], rd[6])
    end
    clk_en <= 1'b0; raw <= ~v[0]; tick(8); `CHK("frozen out", v[0] ^ v[1], cout)
    clk_en <= 1'b1; tick(6); `CHK("resumed out", v[0] ~^ v[1], cout)
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)); p = 8'($random(seed)); pins <= p;
      axi_wr(`CMPD_OFS_PORT, v); tick(4); axi_rd(`CMPD_OFS_PORT);
      `CHK("port read", {24'h0, p & ~v}, rd)
      axi_rd(`CMPD_OFS_MISC); `CHK("analog sel", {24'h0, v}, rd)
    end
    $display("test output done");
    sse <= 1'b0; axi_wr(`CMPD_OFS_CTRL, 8'h81); raw <= 1'b0; tmr_run <= 1'b1; tick(40); tmr_run <= 1'b0; tick(4);
    raw <= 1'b1; tick(20); `CHK("sync holds", 1'b0, cout)
    tmr_run <= 1'b1; tick(40); `CHK("sync follows", 1'b1, cout)
    `CHK("timer counts", 1'b1, tmr_cnt != 8'h00)
    pre_en <= 1'b1; tmr_run <= 1'b0; tick(4); raw <= 1'b0; tick(20); `CHK("pre holds", 1'b1, cout)
    // the raw timer clock falls first; the prescaled one only four cycles later
    tmr_run <= 1'b1; tick(14); `CHK("pre ignores raw clock", 1'b1, cout)
    tick(66); `CHK("pre follows", 1'b0, cout)
    sysclk <= 1'b1; sleep <= 1'b1; raw <= 1'b1; tick(80); `CHK("sleep freeze", 1'b0, cout)
    sleep <= 1'b0; tick(80); `CHK("sleep exit", 1'b1, cout)
    $display("test sync done");
    close_out();
  end
endmodule : comparator_digital_control_test
